//--- fpa_cpu_model.sv
module fpa_cpu_model
  import fpa_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Device handshake
  input wire logic cpu_to_fpu_transfer,
  input wire logic cpu_sync,
  // Bench controls
  input wire logic [CPU_W-1:0] word,
  input wire logic [3:0] lag,
  // CPU outputs
  output logic [CPU_W-1:0] cpu_data,
  output logic cpu_attention
);
  timeunit 1ns;
  timeprecision 1ps;

  // Answer each wait after a chosen delay, hold until sync or the end of the wait
  initial
  begin
    cpu_data = 16'h0;
    cpu_attention = 1'b0;
    forever
    begin
      @(posedge core_clk);
      if (cpu_to_fpu_transfer === 1'b1)
      begin
        repeat (lag) @(posedge core_clk);
        cpu_data <= word;
        repeat (2) @(posedge core_clk);
        cpu_attention <= 1'b1; // Attention with data
        @(posedge core_clk);
        while (cpu_to_fpu_transfer === 1'b1 && cpu_sync !== 1'b1) @(posedge core_clk);
        cpu_attention <= 1'b0;
        cpu_data <= ~word; // Released bus shows inverse
      end
    end
  end
endmodule

//--- fpa_float_add_sub.sv
// Local design decisions: the register offsets and strobed register access.
module fpa_float_add_sub
  import fpa_pkg::*;
#(
  parameter int FRAC_W = 56
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // CPU side
  input wire logic [CPU_W-1:0] cpu_data,
  input wire logic cpu_attention,
  output logic cpu_to_fpu_transfer,
  output logic cpu_sync,
  output logic [15:0] operand_addr,
  output logic minus_zero_event
);

  localparam int AW = FRAC_W + 2;
  localparam logic [AW-1:0] ROUND_ONE = AW'(1);
  localparam logic [EXP_W:0] SHIFT_LAST = 9'h001;

  // Shared arithmetic unit, used at exponent and fraction width
  function automatic logic [AW-1:0] alu_f(input logic [3:0] op, input logic [AW-1:0] a,
                                          input logic [AW-1:0] b);
    case (op)
      ALU_NOT_A: alu_f = ~a;
      ALU_A_MINUS_B: alu_f = a - b;
      ALU_A_PLUS_B: alu_f = a + b;
      ALU_A_MINUS_1: alu_f = a - ROUND_ONE;
      default: alu_f = a;
    endcase
  endfunction

  // Datapath state
  fpa_state_t state_r, state_nxt;
  fpa_class_t cls_r, cls_nxt;
  logic [EXP_W-1:0] dexp_r, dexp_nxt;
  logic [EXP_W-1:0] sexp_r, sexp_nxt;
  logic [AW-1:0] ar_r, ar_nxt;
  logic [FRAC_W-1:0] br_r, br_nxt;
  logic [FRAC_W-1:0] qr_r, qr_nxt;
  logic sd_r, sd_nxt;
  logic ss_r, ss_nxt;
  logic [EXP_W:0] shcnt_r, shcnt_nxt;
  logic zero_r, zero_nxt;
  logic [3:0] cc_r, cc_nxt;
  // Control state
  logic op_sub_r, op_sub_nxt;
  logic dbl_r, dbl_nxt;
  logic trunc_r, trunc_nxt;
  logic mzen_r, mzen_nxt;
  logic [MODE_W-1:0] mode_r, mode_nxt;
  logic [UW_W-1:0] uw_r, uw_nxt;
  logic [CPU_W-1:0] slot_r, slot_nxt;
  logic [15:0] opaddr_r, opaddr_nxt;
  logic mz_sticky_r, mz_sticky_nxt;
  logic xfer_r, xfer_nxt;
  logic sync_r, sync_nxt;
  logic mzev_r, mzev_nxt;
  logic [31:0] rdata_r;
  // Pin synchronisers
  logic attn_s1_r, attn_s2_r, attn_s3_r;
  logic [CPU_W-1:0] data_s1_r, data_s2_r;

  // Bus decode
  wire idle = (state_r == ST_IDLE);
  wire wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
  wire wr_cmd = reg_wr && (reg_addr == OFF_CMD);
  wire wr_dexp = reg_wr && (reg_addr == OFF_DEXP) && idle;
  wire wr_dlo = reg_wr && (reg_addr == OFF_DFRAC_LO) && idle;
  wire wr_dhi = reg_wr && (reg_addr == OFF_DFRAC_HI) && idle;
  wire wr_sexp = reg_wr && (reg_addr == OFF_SEXP) && idle;
  wire wr_slo = reg_wr && (reg_addr == OFF_SFRAC_LO) && idle;
  wire wr_shi = reg_wr && (reg_addr == OFF_SFRAC_HI) && idle;
  wire wr_uwlo = reg_wr && (reg_addr == OFF_UW_LO) && idle;
  wire wr_uwhi = reg_wr && (reg_addr == OFF_UW_HI) && idle;
  wire wr_addr = reg_wr && (reg_addr == OFF_OPADDR) && idle;
  wire start_as = wr_cmd && reg_wdata[CMD_ADDSUB] && idle;
  wire start_ld = wr_cmd && reg_wdata[CMD_LOAD] && idle && !reg_wdata[CMD_ADDSUB];
  wire mz_clr = wr_cmd && reg_wdata[CMD_MZ_CLR];

  // Exponent side of the unit: difference, then shift countdown
  wire [3:0] ea_op = (state_r == ST_ALIGN) ? ALU_A_MINUS_1 : ALU_A_MINUS_B;
  wire [AW-1:0] ea_a = (state_r == ST_ALIGN) ? AW'(shcnt_r) : AW'(dexp_r);
  wire [AW-1:0] ea_full = alu_f(ea_op, ea_a, AW'(sexp_r));
  wire [EXP_W:0] ea_out = ea_full[EXP_W:0];
  wire signed [EXP_W:0] diff_s = signed'(ea_out);
  wire signed [EXP_W:0] lim_s = signed'(dbl_r ? DP_LIMIT : SP_LIMIT);
  wire [EXP_W:0] diff_mag = diff_s[EXP_W] ? EXP_W'(0) - ea_out : ea_out;

  // Exponent-difference classification
  wire fpa_class_t cls_w = (diff_s == 0) ? CL_EQ :
                           (diff_s > 0 && diff_s <= lim_s) ? CL_GT :
                           (diff_s > lim_s) ? CL_MGT :
                           (diff_s > -lim_s) ? CL_LT : CL_MLT;

  // Fraction side of the unit; only destination minus source is formed
  wire sub_mag = op_sub_r ? (ss_r == sd_r) : (ss_r != sd_r);
  wire [3:0] fa_op = (state_r == ST_COMBINE) ? (sub_mag ? ALU_A_MINUS_B : ALU_A_PLUS_B) :
                     (state_r == ST_ZTEST) ? ALU_A_MINUS_1 :
                     (state_r == ST_FINISH) ? ALU_A_PLUS_B : ALU_PASS_A;
  wire [AW-1:0] fa_b = (state_r == ST_FINISH) ? ROUND_ONE : AW'(br_r);
  wire [AW-1:0] fa_out = alu_f(fa_op, ar_r, fa_b);
  wire last_shift = (shcnt_r == SHIFT_LAST);
  wire combined = (cls_r == CL_EQ) || (cls_r == CL_GT) || (cls_r == CL_LT);

  // Load step: exponent mux, complement, accumulator mux
  wire [1:0] emx_sel = uw_r[UW_EMX_LO+1:UW_EMX_LO];
  wire [1:0] accumulator_input_mux_sel = uw_r[UW_ACCUMULATOR_INPUT_MUX_LO+1:UW_ACCUMULATOR_INPUT_MUX_LO];
  wire [CPU_W-1:0] emx_out = (emx_sel == EMX_CPU) ? data_s2_r : '0;
  wire [AW-1:0] ld_alu = alu_f(ALU_NOT_A, AW'(emx_out), '0);
  wire [CPU_W-1:0] accumulator_input_mux_out = (accumulator_input_mux_sel == ACCUMULATOR_INPUT_MUX_ALU) ? ld_alu[CPU_W-1:0] : '0;
  wire must_wait = !uw_r[UW_CNT_REDEF_N] && !uw_r[UW_WAIT_N];
  wire attn_rise = attn_s2_r && !attn_s3_r;
  wire ld_take = (state_r == ST_LD_WAIT) && (!must_wait || attn_rise);
  wire mz_hit = ld_take && mzen_r && ((accumulator_input_mux_out & MZ_MASK) == MZ_PAT);

  // Source operand taken from the temporary slot for memory modes
  wire [FRAC_W-1:0] slot_frac = {1'b1, slot_r[SLOT_FRAC_W-1:0],
                                 {(FRAC_W-SLOT_FRAC_W-1){1'b0}}};

  // Read mux
  wire [31:0] sts_w = {20'h00000, cc_r, 2'h0, mz_sticky_r, zero_r, cls_r, !idle};
  wire [31:0] ctrl_w = {25'h0000000, mode_r, mzen_r, trunc_r, dbl_r, op_sub_r};
  wire [31:0] rd_mux = (reg_addr == OFF_CTRL) ? ctrl_w :
                       (reg_addr == OFF_STATUS) ? sts_w :
                       (reg_addr == OFF_DEXP) ? {23'h000000, sd_r, dexp_r} :
                       (reg_addr == OFF_DFRAC_LO) ? ar_r[31:0] :
                       (reg_addr == OFF_DFRAC_HI) ? 32'(ar_r[AW-1:32]) :
                       (reg_addr == OFF_SEXP) ? {23'h000000, ss_r, sexp_r} :
                       (reg_addr == OFF_SFRAC_LO) ? br_r[31:0] :
                       (reg_addr == OFF_SFRAC_HI) ? 32'(br_r[FRAC_W-1:32]) :
                       (reg_addr == OFF_UW_LO) ? uw_r[31:0] :
                       (reg_addr == OFF_UW_HI) ? uw_r[UW_W-1:32] :
                       (reg_addr == OFF_SLOT) ? 32'(slot_r) :
                       (reg_addr == OFF_OPADDR) ? 32'(opaddr_r) : 32'h00000000;

  // Next-state and datapath sequencing
  always_comb
  begin
    state_nxt = state_r;
    cls_nxt = cls_r;
    dexp_nxt = dexp_r;
    sexp_nxt = sexp_r;
    ar_nxt = ar_r;
    br_nxt = br_r;
    qr_nxt = qr_r;
    sd_nxt = sd_r;
    ss_nxt = ss_r;
    shcnt_nxt = shcnt_r;
    zero_nxt = zero_r;
    cc_nxt = cc_r;
    op_sub_nxt = op_sub_r;
    dbl_nxt = dbl_r;
    trunc_nxt = trunc_r;
    mzen_nxt = mzen_r;
    mode_nxt = mode_r;
    uw_nxt = uw_r;
    slot_nxt = slot_r;
    opaddr_nxt = opaddr_r;
    xfer_nxt = 1'b0;
    sync_nxt = 1'b0;
    mzev_nxt = 1'b0;
    mz_sticky_nxt = (mz_sticky_r && !mz_clr) || mz_hit;
    if (wr_ctrl && idle)
    begin
      op_sub_nxt = reg_wdata[CTRL_SUB];
      dbl_nxt = reg_wdata[CTRL_DBL];
      trunc_nxt = reg_wdata[CTRL_TRUNC];
      mzen_nxt = reg_wdata[CTRL_MZEN];
      mode_nxt = reg_wdata[CTRL_MODE_LO+MODE_W-1:CTRL_MODE_LO];
    end
    if (wr_dexp)
    begin
      dexp_nxt = reg_wdata[EXP_W-1:0];
      sd_nxt = reg_wdata[EXP_SIGN_BIT];
    end
    if (wr_dlo)
      ar_nxt[31:0] = reg_wdata;
    if (wr_dhi)
      ar_nxt[AW-1:32] = reg_wdata[AW-33:0];
    if (wr_sexp)
    begin
      sexp_nxt = reg_wdata[EXP_W-1:0];
      ss_nxt = reg_wdata[EXP_SIGN_BIT];
    end
    if (wr_slo)
    begin
      br_nxt[31:0] = reg_wdata;
      qr_nxt[31:0] = reg_wdata;
    end
    if (wr_shi)
    begin
      br_nxt[FRAC_W-1:32] = reg_wdata[FRAC_W-33:0];
      qr_nxt[FRAC_W-1:32] = reg_wdata[FRAC_W-33:0];
    end
    if (wr_uwlo)
      uw_nxt[31:0] = reg_wdata;
    if (wr_uwhi)
      uw_nxt[UW_W-1:32] = reg_wdata;
    if (wr_addr)
      opaddr_nxt = reg_wdata[15:0];
    unique case (state_r)
      ST_IDLE:
      begin
        if (start_as)
        begin
          state_nxt = ST_CLASS;
          zero_nxt = 1'b0;
          if (mode_r != '0)
          begin
            // Memory operand was staged in the slot by the load step
            ss_nxt = slot_r[SLOT_SIGN];
            sexp_nxt = slot_r[SLOT_EXP_LO+EXP_W-1:SLOT_EXP_LO];
            br_nxt = slot_frac;
            qr_nxt = slot_frac;
          end
        end
        else if (start_ld)
        begin
          state_nxt = ST_LD_WAIT;
        end
      end
      ST_CLASS:
      begin
        cls_nxt = cls_w;
        shcnt_nxt = diff_mag;
        unique case (cls_w)
          CL_EQ: state_nxt = ST_COMBINE;
          CL_GT, CL_LT: state_nxt = ST_ALIGN;
          CL_MGT: state_nxt = ST_FINISH;
          CL_MLT:
          begin
            dexp_nxt = sexp_r;
            ar_nxt = AW'(br_r);
            sd_nxt = op_sub_r ? !ss_r : ss_r;
            state_nxt = ST_FINISH;
          end
        endcase
      end
      ST_ALIGN:
      begin
        // One place per cycle
        shcnt_nxt = ea_out;
        if (cls_r == CL_GT)
        begin
          qr_nxt = qr_r >> 1;
          if (last_shift)
            br_nxt = qr_r >> 1;
        end
        else
        begin
          ar_nxt = ar_r >> 1;
          if (last_shift)
            dexp_nxt = sexp_r;
        end
        if (last_shift)
          state_nxt = ST_COMBINE;
      end
      ST_COMBINE:
      begin
        ar_nxt = fa_out;
        if (sub_mag && fa_out[AW-1])
          sd_nxt = op_sub_r ? !ss_r : ss_r;
        state_nxt = ST_ZTEST;
      end
      ST_ZTEST:
      begin
        // Negative cannot be zero; positive minus one that turns negative was zero
        zero_nxt = !ar_r[AW-1] && fa_out[AW-1];
        state_nxt = ST_FINISH;
      end
      ST_FINISH:
      begin
        if (combined && !zero_r)
          ar_nxt = trunc_r ? (ar_r & ~ROUND_ONE) : (fa_out & ~ROUND_ONE);
        cc_nxt = {sd_r && !zero_r, zero_r, 2'b00};
        state_nxt = ST_IDLE;
      end
      ST_LD_WAIT:
      begin
        xfer_nxt = !ld_take && (emx_sel == EMX_CPU);
        if (ld_take)
        begin
          if (uw_r[UW_SLOT_LO+2:UW_SLOT_LO] == SLOT_SEL)
            slot_nxt = ~accumulator_input_mux_out;
          if (!uw_r[UW_NO_INC])
            opaddr_nxt = opaddr_r + ADDR_STEP;
          if (uw_r[UW_CC_LO+1:UW_CC_LO] == CC_LOAD)
            // Mux carries the complement, so codes are taken from its inverse
            cc_nxt = {!accumulator_input_mux_out[CPU_W-1], accumulator_input_mux_out == '1, 2'b00};
          sync_nxt = !uw_r[UW_SYNC_N];
          mzev_nxt = mz_hit;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Pin synchronisers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      attn_s1_r <= 1'b0;
      attn_s2_r <= 1'b0;
      attn_s3_r <= 1'b0;
      data_s1_r <= '0;
      data_s2_r <= '0;
    end
    else
    begin
      attn_s1_r <= cpu_attention;
      attn_s2_r <= attn_s1_r;
      attn_s3_r <= attn_s2_r;
      data_s1_r <= cpu_data;
      data_s2_r <= data_s1_r;
    end
  end

  // Register update
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      cls_r <= CL_EQ;
      dexp_r <= '0;
      sexp_r <= '0;
      ar_r <= '0;
      br_r <= '0;
      qr_r <= '0;
      sd_r <= 1'b0;
      ss_r <= 1'b0;
      shcnt_r <= '0;
      zero_r <= 1'b0;
      cc_r <= '0;
      op_sub_r <= 1'b0;
      dbl_r <= 1'b0;
      trunc_r <= 1'b0;
      mzen_r <= 1'b0;
      mode_r <= '0;
      uw_r <= '1;
      slot_r <= '0;
      opaddr_r <= '0;
      mz_sticky_r <= 1'b0;
      xfer_r <= 1'b0;
      sync_r <= 1'b0;
      mzev_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cls_r <= cls_nxt;
      dexp_r <= dexp_nxt;
      sexp_r <= sexp_nxt;
      ar_r <= ar_nxt;
      br_r <= br_nxt;
      qr_r <= qr_nxt;
      sd_r <= sd_nxt;
      ss_r <= ss_nxt;
      shcnt_r <= shcnt_nxt;
      zero_r <= zero_nxt;
      cc_r <= cc_nxt;
      op_sub_r <= op_sub_nxt;
      dbl_r <= dbl_nxt;
      trunc_r <= trunc_nxt;
      mzen_r <= mzen_nxt;
      mode_r <= mode_nxt;
      uw_r <= uw_nxt;
      slot_r <= slot_nxt;
      opaddr_r <= opaddr_nxt;
      mz_sticky_r <= mz_sticky_nxt;
      xfer_r <= xfer_nxt;
      sync_r <= sync_nxt;
      mzev_r <= mzev_nxt;
      rdata_r <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = rdata_r;
  assign cpu_to_fpu_transfer = xfer_r;
  assign cpu_sync = sync_r;
  assign operand_addr = opaddr_r;
  assign minus_zero_event = mzev_r;

endmodule

//--- fpa_float_add_sub_props.sv
module fpa_float_add_sub_props
  import fpa_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // CPU side
  input wire logic [CPU_W-1:0] cpu_data,
  input wire logic cpu_attention,
  input wire logic cpu_to_fpu_transfer,
  input wire logic cpu_sync,
  input wire logic [15:0] operand_addr,
  input wire logic minus_zero_event
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Waiting with no attention for four cycles
  sequence s_quiet_wait;
    (cpu_to_fpu_transfer && !cpu_attention) [*4];
  endsequence

  // Attention arriving during a wait
  sequence s_attn_in_wait;
    $rose(cpu_attention) && cpu_to_fpu_transfer;
  endsequence

  // Read data is zero unless a read was strobed
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");

  // Sync is a single cycle pulse
  property p_sync_pulse;
    cpu_sync |=> !cpu_sync;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync too long");

  // Sync marks the end of a wait
  property p_sync_end;
    cpu_sync |-> !cpu_to_fpu_transfer && $past(cpu_to_fpu_transfer);
  endproperty
  a_sync_end: assert property (p_sync_end) else $error("sync outside step end");

  // Minus zero event is a single cycle pulse
  property p_mz_pulse;
    minus_zero_event |=> !minus_zero_event;
  endproperty
  a_mz_pulse: assert property (p_mz_pulse) else $error("event too long");

  // Event only for a minus zero word from the CPU
  property p_mz_cause;
    minus_zero_event |-> (cpu_data & MZ_MASK) == (MZ_MASK & ~MZ_PAT);
  endproperty
  a_mz_cause: assert property (p_mz_cause) else $error("event without minus zero");

  // Address moves only by a write or a step of two
  property p_addr_step;
    !$past(reg_wr) && $changed(operand_addr) |-> operand_addr == $past(operand_addr) + 16'h2;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address step wrong");

  // No attention keeps the step stalled
  property p_stall;
    s_quiet_wait |=> cpu_to_fpu_transfer;
  endproperty
  a_stall: assert property (p_stall) else $error("wait ended early");

  // Attention ends the wait within a few cycles
  property p_take;
    s_attn_in_wait |-> ##[1:6] !cpu_to_fpu_transfer;
  endproperty
  a_take: assert property (p_take) else $error("attention not taken");
endmodule

//--- fpa_float_add_sub_tb.sv
module fpa_float_add_sub_tb
  import fpa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [CPU_W-1:0] cpu_data;
  logic cpu_attention;
  logic cpu_to_fpu_transfer;
  logic cpu_sync;
  logic [15:0] operand_addr;
  logic minus_zero_event;
  logic [CPU_W-1:0] word;
  logic [3:0] lag;
  logic sd, ss, sub, dbl, trunc, e_sign, e_zero;
  logic [2:0] mode;
  logic [7:0] dexp, sexp, e_exp;
  logic [55:0] dfrac, sfrac;
  logic [57:0] e_frac;
  logic [15:0] e_addr;
  logic [15:0] e_slot = 16'h0;
  fpa_class_t e_cls;
  int n_errors;
  int tests_run;
  int n_sync;
  int n_mz;

  fpa_float_add_sub DUT (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_data(cpu_data), .cpu_attention(cpu_attention),
    .cpu_to_fpu_transfer(cpu_to_fpu_transfer), .cpu_sync(cpu_sync),
    .operand_addr(operand_addr), .minus_zero_event(minus_zero_event));

  fpa_cpu_model u_cpu (.core_clk(core_clk), .cpu_to_fpu_transfer(cpu_to_fpu_transfer),
    .cpu_sync(cpu_sync), .word(word), .lag(lag), .cpu_data(cpu_data),
    .cpu_attention(cpu_attention));

  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Count handshake pulses
  always @(posedge core_clk)
  begin
    if (cpu_sync === 1'b1) n_sync++;
    if (minus_zero_event === 1'b1) n_mz++;
  end

  task automatic complete_run();
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] want);
    tests_run++;
    if (got !== want)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, want, got);
    end
  endtask

  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask

  // Expected add or subtract result
  task automatic predict();
    int d;
    int lim;
    logic [57:0] a;
    logic [57:0] b;
    logic eff_add;
    // Memory modes take the source from the staged slot word
    if (mode != 3'h0) {ss, sexp, sfrac} = {e_slot[15], e_slot[14:7], 1'b1, e_slot[6:0], 48'h0};
    lim = dbl ? 57 : 25;
    d = int'(dexp) - int'(sexp);
    a = {2'b00, dfrac};
    b = {2'b00, sfrac};
    e_sign = sd;
    e_exp = dexp;
    e_frac = a;
    e_zero = 1'b0;
    eff_add = (sd == ss) ^ sub;
    e_cls = d > lim ? CL_MGT : d <= -lim ? CL_MLT : d > 0 ? CL_GT : d < 0 ? CL_LT : CL_EQ;
    if (e_cls == CL_MLT)
    begin
      e_exp = sexp;
      e_frac = b;
      e_sign = ss ^ sub;
    end
    else if (e_cls != CL_MGT)
    begin
      if (d > 0) b = b >> d;
      if (d < 0) a = a >> (-d);
      if (d < 0) e_exp = sexp;
      e_frac = eff_add ? a + b : a - b;
      if (!eff_add && e_frac[57]) e_sign = ss ^ sub;
      e_zero = e_frac == 58'h0;
      if (!e_zero) e_frac = (trunc ? e_frac : e_frac + 58'h1) & ~58'h1;
    end
  endtask

  task automatic addsub();
    logic [31:0] s;
    logic [31:0] st;
    wr(OFF_CTRL, {25'h0, mode, 1'b1, trunc, dbl, sub});
    wr(OFF_DEXP, {23'h0, sd, dexp});
    wr(OFF_DFRAC_LO, dfrac[31:0]);
    wr(OFF_DFRAC_HI, {8'h0, dfrac[55:32]});
    wr(OFF_SEXP, {23'h0, ss, sexp});
    wr(OFF_SFRAC_LO, sfrac[31:0]);
    wr(OFF_SFRAC_HI, {8'h0, sfrac[55:32]});
    wr(OFF_CMD, 32'h1);
    for (int i = 0; i < 80; i++)
    begin
      rd(OFF_STATUS, st);
      if (st[STS_BUSY] === 1'b0) break;
    end
    predict();
    chk("class", st[STS_CLASS_LO+:3], e_cls);
    rd(OFF_DEXP, s);
    chk("dexp", s[8:0], {e_sign, e_exp});
    rd(OFF_DFRAC_LO, s);
    chk("frac_lo", s, e_frac[31:0]);
    rd(OFF_DFRAC_HI, s);
    chk("frac_hi", s[25:0], e_frac[57:32]);
    if (e_cls <= CL_LT) chk("cc", st[STS_CC_LO+:4], {e_sign & !e_zero, e_zero, 2'b00});
    if (e_cls <= CL_LT) chk("zero", st[STS_ZERO], e_zero);
  endtask

  // One load step from the CPU
  task automatic load(input logic [15:0] w, input logic [3:0] lg, input logic quiet);
    logic [31:0] s;
    logic [63:0] uw;
    int ns;
    int nm;
    uw = '1;
    uw[UW_SYNC_N] = quiet;
    uw[UW_NO_INC] = quiet;
    uw[UW_CNT_REDEF_N] = 1'b0;
    uw[UW_WAIT_N] = 1'b0;
    uw[UW_EMX_LO+:2] = EMX_CPU;
    uw[UW_CC_LO+:2] = CC_LOAD;
    uw[UW_SLOT_LO+:3] = SLOT_SEL;
    uw[UW_ACCUMULATOR_INPUT_MUX_LO+:2] = ACCUMULATOR_INPUT_MUX_ALU;
    wr(OFF_UW_LO, uw[31:0]);
    wr(OFF_UW_HI, uw[63:32]);
    word <= w;
    lag <= lg;
    ns = n_sync;
    nm = n_mz;
    wr(OFF_CMD, 32'h2);
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 40 && cpu_to_fpu_transfer !== 1'b0; i++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    chk("sync", n_sync - ns, !quiet);
    chk("mz", n_mz - nm, w[15] && w[14:7] == 8'h0);
    rd(OFF_SLOT, s);
    chk("slot", s[15:0], w);
    e_addr = e_addr + (quiet ? 16'h0 : 16'h2);
    rd(OFF_OPADDR, s);
    chk("addr", s[15:0], e_addr);
    rd(OFF_STATUS, s);
    chk("load_cc", s[STS_CC_LO+:4], {w[15], w == 16'h0, 2'b00});
  endtask

  // Main sequence
  initial
  begin
    logic [31:0] s;
    int d;
    int dt[11] = '{0, 1, 25, 26, -1, -24, -25, 57, 58, -57, -56};
    {rst_n, reg_addr, reg_wdata, reg_wr, reg_rd, word, lag} = '0;
    n_errors = 0;
    tests_run = 0;
    n_sync = 0;
    n_mz = 0;
    s = $urandom(67184);
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("idle", {cpu_sync, cpu_to_fpu_transfer, minus_zero_event, operand_addr}, 0);
    rd(OFF_UW_HI, s);
    chk("uw_reset", s, 32'hffffffff);
    rd(8'h3c, s);
    chk("unmapped", s, 0);
    for (int i = 0; i < 30; i++)
    begin
      {sd, ss, sub, trunc, mode} = 7'($urandom);
      dfrac = 56'({$urandom, $urandom});
      sfrac = 56'({$urandom, $urandom});
      dexp = 8'h50 + 8'($urandom_range(0, 40));
      dbl = (i < 11) ? (i >= 7) : 1'($urandom);
      d = (i < 11) ? dt[i] : int'($urandom_range(0, 140)) - 70;
      sexp = 8'(int'(dexp) - d);
      if (i < 11) mode = 3'h0;
      if (i == 0) sfrac = dfrac;
      if (i == 0) {sub, ss} = {1'b1, sd};
      addsub();
    end
    e_addr = 16'h0200;
    wr(OFF_OPADDR, {16'h0, e_addr});
    wr(OFF_CTRL, 32'h18);
    load(16'h8000, 4'h0, 1'b0);
    load(16'h807f, 4'h9, 1'b0);
    load(16'h0000, 4'h3, 1'b1);
    load(16'h8080, 4'h1, 1'b0);
    for (int i = 0; i < 4; i++) load(16'($urandom), 4'($urandom), 1'(i));
    rd(OFF_STATUS, s);
    chk("mz_sticky", s[STS_MZ], 1'b1);
    wr(OFF_CMD, 32'h4);
    rd(OFF_STATUS, s);
    chk("mz_clear", s[STS_MZ], 1'b0);
    complete_run();
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    complete_run();
  end
endmodule

bind fpa_float_add_sub fpa_float_add_sub_props u_props (.core_clk(core_clk), .rst_n(rst_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_data(cpu_data),
  .cpu_attention(cpu_attention), .cpu_to_fpu_transfer(cpu_to_fpu_transfer),
  .cpu_sync(cpu_sync), .operand_addr(operand_addr), .minus_zero_event(minus_zero_event));

//--- fpa_pkg.sv
package fpa_pkg;

  // Operand widths
  localparam int EXP_W = 8;
  localparam int CPU_W = 16;
  localparam int UW_W = 64;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_DEXP = 8'h0c;
  localparam logic [7:0] OFF_DFRAC_LO = 8'h10;
  localparam logic [7:0] OFF_DFRAC_HI = 8'h14;
  localparam logic [7:0] OFF_SEXP = 8'h18;
  localparam logic [7:0] OFF_SFRAC_LO = 8'h1c;
  localparam logic [7:0] OFF_SFRAC_HI = 8'h20;
  localparam logic [7:0] OFF_UW_LO = 8'h24;
  localparam logic [7:0] OFF_UW_HI = 8'h28;
  localparam logic [7:0] OFF_SLOT = 8'h2c;
  localparam logic [7:0] OFF_OPADDR = 8'h30;

  // Control register fields
  localparam int CTRL_SUB = 0;
  localparam int CTRL_DBL = 1;
  localparam int CTRL_TRUNC = 2;
  localparam int CTRL_MZEN = 3;
  localparam int CTRL_MODE_LO = 4;
  localparam int MODE_W = 3;

  // Command register bits
  localparam int CMD_ADDSUB = 0;
  localparam int CMD_LOAD = 1;
  localparam int CMD_MZ_CLR = 2;

  // Exponent register sign position, status fields
  localparam int EXP_SIGN_BIT = 8;
  localparam int STS_BUSY = 0;
  localparam int STS_CLASS_LO = 1;
  localparam int STS_ZERO = 4;
  localparam int STS_MZ = 5;
  localparam int STS_CC_LO = 8;

  // Shared arithmetic unit operation codes
  localparam logic [3:0] ALU_NOT_A = 4'h0;
  localparam logic [3:0] ALU_A_MINUS_B = 4'h2;
  localparam logic [3:0] ALU_A_PLUS_B = 4'h9;
  localparam logic [3:0] ALU_A_MINUS_1 = 4'hd;
  localparam logic [3:0] ALU_PASS_A = 4'hf;

  // Alignment limits, 25 single and 57 double
  localparam logic [EXP_W:0] SP_LIMIT = 9'h019;
  localparam logic [EXP_W:0] DP_LIMIT = 9'h039;

  // Control word bit positions of the load step
  localparam int UW_SYNC_N = 60;
  localparam int UW_CNT_REDEF_N = 58;
  localparam int UW_WAIT_N = 54;
  localparam int UW_NO_INC = 48;
  localparam int UW_EMX_LO = 45;
  localparam int UW_CC_LO = 43;
  localparam int UW_SLOT_LO = 35;
  localparam int UW_ACCUMULATOR_INPUT_MUX_LO = 30;
  localparam logic [1:0] EMX_CPU = 2'h1;
  localparam logic [1:0] ACCUMULATOR_INPUT_MUX_ALU = 2'h1;
  localparam logic [2:0] SLOT_SEL = 3'h1;
  localparam logic [1:0] CC_LOAD = 2'h0;

  // Load data handling
  localparam logic [15:0] ADDR_STEP = 16'h0002;
  localparam logic [CPU_W-1:0] MZ_MASK = 16'hff80;
  localparam logic [CPU_W-1:0] MZ_PAT = 16'h7f80;
  localparam int SLOT_SIGN = 15;
  localparam int SLOT_EXP_LO = 7;
  localparam int SLOT_FRAC_W = 7;

  typedef enum logic [2:0] {CL_EQ, CL_GT, CL_LT, CL_MGT, CL_MLT} fpa_class_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CLASS, ST_ALIGN, ST_COMBINE, ST_ZTEST, ST_FINISH, ST_LD_WAIT
  } fpa_state_t;

endpackage
